/* File: mdt_bus_arbiter.v */
// Internal bus arbiter between the CPU and the transfer engine.
// Assumes both masters hold their request for the whole tenure.
`timescale 1ns/1ps

module mdt_bus_arbiter (
   input wire clk,
   input wire rst_b,
   input wire cpu_req,
   input wire eng_req,
   output wire cpu_gnt,
   output wire eng_gnt
);

   localparam OWN_NONE = 2'h0;
   localparam OWN_CPU = 2'h1;
   localparam OWN_ENG = 2'h2;

   reg [1:0] owner_ff;
   reg [1:0] nxt_owner;

   // ----------------------------------------
   // Ownership changes only when the holder lets go
   // ----------------------------------------
   always @* begin
      nxt_owner = owner_ff;
      case (owner_ff)
         OWN_NONE: begin
            if (eng_req)
               nxt_owner = OWN_ENG;
            else if (cpu_req)
               nxt_owner = OWN_CPU;
         end
         OWN_CPU: begin
            if (!cpu_req)
               nxt_owner = eng_req ? OWN_ENG : OWN_NONE;
         end
         OWN_ENG: begin
            if (!eng_req)
               nxt_owner = cpu_req ? OWN_CPU : OWN_NONE;
         end
         default: nxt_owner = OWN_NONE;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b)
         owner_ff <= OWN_NONE;
      else
         owner_ff <= nxt_owner;
   end

   // One master at a time
   assign cpu_gnt = (owner_ff == OWN_CPU);
   assign eng_gnt = (owner_ff == OWN_ENG);

endmodule

/* File: mdt_engine.v */
// Descriptor transfer engine: activation, descriptor fetch, data moves,
// descriptor write-back, chaining, and routing of interrupt requests.
// Assumes memory answers each request with mem_ack, read data valid with it,
// and that interrupt sources are levels on this clock.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mdt_regs.vh"

module mdt_engine (
   input wire clk,
   input wire rst_b,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [23:0] src_req,
   output wire [23:0] cpu_irq,
   input wire cpu_bus_req,
   output wire cpu_bus_gnt,
   output wire mem_req,
   output reg [23:0] mem_addr,
   output reg mem_we,
   output reg [1:0] mem_size,
   output reg [31:0] mem_wdata,
   input wire [31:0] mem_rdata,
   input wire mem_ack
);

   localparam S_IDLE = 4'h0;
   localparam S_VEC = 4'h1;
   localparam S_RDA = 4'h2;
   localparam S_RDB = 4'h3;
   localparam S_RDC = 4'h4;
   localparam S_DRD = 4'h5;
   localparam S_DWR = 4'h6;
   localparam S_WBA = 4'h7;
   localparam S_WBB = 4'h8;
   localparam S_WBC = 4'h9;

   // ----------------------------------------
   // Source tables
   // ----------------------------------------
   // Vector number of each source, index 0 ranks highest
   function [6:0] src_vec;
      input [4:0] i;
      begin
         case (i)
            5'd0: src_vec = 7'd16;
            5'd1: src_vec = 7'd17;
            5'd2: src_vec = 7'd18;
            5'd3: src_vec = 7'd28;
            5'd4: src_vec = 7'd48;
            5'd5: src_vec = 7'd49;
            5'd6: src_vec = 7'd52;
            5'd7: src_vec = 7'd54;
            5'd8: src_vec = 7'd64;
            5'd9: src_vec = 7'd65;
            5'd10: src_vec = 7'd68;
            5'd11: src_vec = 7'd69;
            5'd12: src_vec = 7'd72;
            5'd13: src_vec = 7'd73;
            5'd14: src_vec = 7'd76;
            5'd15: src_vec = 7'd77;
            5'd16: src_vec = 7'd81;
            5'd17: src_vec = 7'd82;
            5'd18: src_vec = 7'd85;
            5'd19: src_vec = 7'd86;
            5'd20: src_vec = 7'd89;
            5'd21: src_vec = 7'd90;
            5'd22: src_vec = 7'd92;
            default: src_vec = 7'd94;
         endcase
      end
   endfunction

   // Position of each source's enable bit in {A,B,C,D}
   function [4:0] src_bit;
      input [4:0] i;
      begin
         case (i)
            5'd0: src_bit = 5'd31;
            5'd1: src_bit = 5'd30;
            5'd2: src_bit = 5'd29;
            5'd3: src_bit = 5'd27;
            5'd4: src_bit = 5'd26;
            5'd5: src_bit = 5'd25;
            5'd6: src_bit = 5'd24;
            5'd7: src_bit = 5'd23;
            5'd8: src_bit = 5'd18;
            5'd9: src_bit = 5'd17;
            5'd10: src_bit = 5'd16;
            default: src_bit = 5'd26 - i;
         endcase
      end
   endfunction

   // One address step after a unit moves
   function [23:0] step;
      input [23:0] p;
      input [1:0] m;
      input sz;
      begin
         case (m)
            `MDT_AM_INC: step = p + {22'h000000, sz, ~sz};
            `MDT_AM_DEC: step = p - {22'h000000, sz, ~sz};
            default: step = p;
         endcase
      end
   endfunction

   // Back to the first unit of a repeat area of n units
   function [23:0] rewind;
      input [23:0] p;
      input [1:0] m;
      input sz;
      input [7:0] n;
      reg [7:0] nm1;
      reg [23:0] off;
      begin
         nm1 = n - 8'h01;
         off = sz ? {15'h0000, nm1, 1'b0} : {16'h0000, nm1};
         case (m)
            `MDT_AM_INC: rewind = p - off;
            `MDT_AM_DEC: rewind = p + off;
            default: rewind = p;
         endcase
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [3:0] state_ff;
   reg [31:0] en_ff;
   reg [7:0] swv_ff;
   reg act_sw_ff;
   reg [4:0] act_src_ff;
   reg [23:0] vec_addr_ff;
   reg [23:0] desc_ff;
   reg [7:0] mra_ff;
   reg [7:0] mrb_ff;
   reg [23:0] sp_ff;
   reg [23:0] dp_ff;
   reg [15:0] cra_ff;
   reg [15:0] crb_ff;
   reg [15:0] data_ff;
   reg [23:0] blk_start_ff;
   reg last_ff;
   reg eng_req_ff;
   reg sw_done_ff;
   wire eng_gnt;
   wire [23:0] pend;
   reg any_pend;
   reg [4:0] pick;
   integer k;

   wire sz = mra_ff[`MDT_MRA_SZ];
   wire dts = mra_ff[`MDT_MRA_DTS];
   wire [1:0] md = mra_ff[`MDT_MRA_MD];
   wire chain = mrb_ff[`MDT_MRB_CHAIN];
   wire disel = mrb_ff[`MDT_MRB_DISEL];
   wire [23:0] sp_step = step(sp_ff, mra_ff[`MDT_MRA_SM], sz);
   wire [23:0] dp_step = step(dp_ff, mra_ff[`MDT_MRA_DM], sz);

   // ----------------------------------------
   // Request routing and priority
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `MDT_NSRC; g = g + 1) begin : route
         // Enabled sources go to the engine only; mask levels never see them
         assign pend[g] = src_req[g] & en_ff[src_bit(g)];
         assign cpu_irq[g] = src_req[g] & ~en_ff[src_bit(g)];
      end
   endgenerate

   // Lowest index wins
   always @* begin
      pick = 5'd0;
      any_pend = 1'b0;
      for (k = `MDT_NSRC - 1; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            pick = k[4:0];
            any_pend = 1'b1;
         end
      end
   end

   mdt_bus_arbiter u_arb (
      .clk(clk),
      .rst_b(rst_b),
      .cpu_req(cpu_bus_req),
      .eng_req(eng_req_ff),
      .cpu_gnt(cpu_bus_gnt),
      .eng_gnt(eng_gnt)
   );

   // ----------------------------------------
   // Bus master side
   // ----------------------------------------
   // The engine only drives the bus while granted
   assign mem_req = eng_gnt && (state_ff != S_IDLE);

   // Descriptor words in fixed order, three longwords
   always @* begin
      mem_addr = vec_addr_ff;
      mem_we = 1'b0;
      mem_size = `MDT_SIZE_LONG;
      mem_wdata = 32'h00000000;
      case (state_ff)
         S_VEC: mem_size = `MDT_SIZE_WORD;
         S_RDA: mem_addr = desc_ff;
         S_RDB: mem_addr = desc_ff + 24'h000004;
         S_RDC: mem_addr = desc_ff + 24'h000008;
         S_DRD: begin
            mem_addr = sp_ff;
            mem_size = sz ? `MDT_SIZE_WORD : `MDT_SIZE_BYTE;
         end
         S_DWR: begin
            mem_addr = dp_ff;
            mem_we = 1'b1;
            mem_size = sz ? `MDT_SIZE_WORD : `MDT_SIZE_BYTE;
            mem_wdata = {16'h0000, sz ? data_ff : {8'h00, data_ff[7:0]}};
         end
         S_WBA: begin
            mem_addr = desc_ff;
            mem_we = 1'b1;
            mem_wdata = {mra_ff, sp_ff};
         end
         S_WBB: begin
            mem_addr = desc_ff + 24'h000004;
            mem_we = 1'b1;
            mem_wdata = {mrb_ff, dp_ff};
         end
         S_WBC: begin
            mem_addr = desc_ff + 24'h000008;
            mem_we = 1'b1;
            mem_wdata = {cra_ff, crb_ff};
         end
         default: mem_addr = vec_addr_ff;
      endcase
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= S_IDLE;
         en_ff <= `MDT_RST_EN;
         swv_ff <= `MDT_RST_SWV;
         act_sw_ff <= 1'b0;
         act_src_ff <= 5'd0;
         vec_addr_ff <= 24'h000000;
         desc_ff <= 24'h000000;
         mra_ff <= 8'h00;
         mrb_ff <= 8'h00;
         sp_ff <= 24'h000000;
         dp_ff <= 24'h000000;
         cra_ff <= 16'h0000;
         crb_ff <= 16'h0000;
         data_ff <= 16'h0000;
         blk_start_ff <= 24'h000000;
         last_ff <= 1'b0;
         eng_req_ff <= 1'b0;
         sw_done_ff <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         case (state_ff)
            S_IDLE: begin
               // Software request ranks above every source
               if (swv_ff[`MDT_SWV_GO]) begin
                  act_sw_ff <= 1'b1;
                  vec_addr_ff <= `MDT_VEC_BASE + {16'h0000, swv_ff[6:0], 1'b0};
                  eng_req_ff <= 1'b1;
                  state_ff <= S_VEC;
               end else if (any_pend) begin
                  act_sw_ff <= 1'b0;
                  act_src_ff <= pick;
                  vec_addr_ff <= `MDT_VEC_BASE + {16'h0000, src_vec(pick), 1'b0};
                  eng_req_ff <= 1'b1;
                  state_ff <= S_VEC;
               end
            end
            S_VEC: if (mem_req && mem_ack) begin
               // Descriptors live in the top RAM page
               desc_ff <= {`MDT_RAM_PAGE, mem_rdata[15:0]};
               state_ff <= S_RDA;
            end
            S_RDA: if (mem_req && mem_ack) begin
               mra_ff <= mem_rdata[31:24];
               sp_ff <= mem_rdata[23:0];
               state_ff <= S_RDB;
            end
            S_RDB: if (mem_req && mem_ack) begin
               mrb_ff <= mem_rdata[31:24];
               dp_ff <= mem_rdata[23:0];
               state_ff <= S_RDC;
            end
            S_RDC: if (mem_req && mem_ack) begin
               cra_ff <= mem_rdata[31:16];
               crb_ff <= mem_rdata[15:0];
               // Pointers are already loaded here, so the block side start is known
               blk_start_ff <= dts ? sp_ff : dp_ff;
               last_ff <= 1'b0;
               state_ff <= S_DRD;
            end
            S_DRD: if (mem_req && mem_ack) begin
               data_ff <= sz ? mem_rdata[15:0] : {8'h00, mem_rdata[7:0]};
               state_ff <= S_DWR;
            end
            S_DWR: if (mem_req && mem_ack) begin
               // Both pointers step per unit by their own mode
               sp_ff <= sp_step;
               dp_ff <= dp_step;
               state_ff <= S_WBA;
               case (md)
                  `MDT_MD_REPEAT: begin
                     // Area end: reload count and area pointer, never finishes
                     if (cra_ff[7:0] == 8'h01) begin
                        cra_ff[7:0] <= cra_ff[15:8];
                        if (dts)
                           sp_ff <= rewind(sp_ff, mra_ff[`MDT_MRA_SM], sz, cra_ff[15:8]);
                        else
                           dp_ff <= rewind(dp_ff, mra_ff[`MDT_MRA_DM], sz, cra_ff[15:8]);
                     end else begin
                        cra_ff[7:0] <= cra_ff[7:0] - 8'h01;
                     end
                  end
                  `MDT_MD_BLOCK: begin
                     if (cra_ff[7:0] != 8'h01) begin
                        // Block still running: move the next unit now
                        cra_ff[7:0] <= cra_ff[7:0] - 8'h01;
                        state_ff <= S_DRD;
                     end else begin
                        // Block done: restore block side, count one block
                        cra_ff[7:0] <= cra_ff[15:8];
                        if (dts)
                           sp_ff <= blk_start_ff;
                        else
                           dp_ff <= blk_start_ff;
                        crb_ff <= crb_ff - 16'h0001;
                        last_ff <= (crb_ff == 16'h0001);
                     end
                  end
                  default: begin
                     // Zero count stands for 65536 through the wrap
                     cra_ff <= cra_ff - 16'h0001;
                     last_ff <= (cra_ff == 16'h0001);
                  end
               endcase
            end
            S_WBA: if (mem_req && mem_ack)
               state_ff <= S_WBB;
            S_WBB: if (mem_req && mem_ack)
               state_ff <= S_WBC;
            S_WBC: if (mem_req && mem_ack) begin
               if (chain) begin
                  // Next descriptor in the same activation
                  desc_ff <= desc_ff + `MDT_DESC_STRIDE;
                  state_ff <= S_RDA;
               end else begin
                  eng_req_ff <= 1'b0;
                  state_ff <= S_IDLE;
                  if (act_sw_ff) begin
                     swv_ff[`MDT_SWV_GO] <= 1'b0;
                     sw_done_ff <= 1'b1;
                  end else if (disel || last_ff) begin
                     // Dropping the enable hands the request to the CPU
                     en_ff[src_bit(act_src_ff)] <= 1'b0;
                  end
               end
            end
            default: state_ff <= S_IDLE;
         endcase

         // Software writes come last so they win over engine updates
         if (reg_wr) begin
            case (reg_addr)
               `MDT_OFS_EN_A: en_ff[31:24] <= reg_wdata;
               `MDT_OFS_EN_B: en_ff[23:16] <= reg_wdata;
               `MDT_OFS_EN_C: en_ff[15:8] <= reg_wdata;
               `MDT_OFS_EN_D: en_ff[7:0] <= reg_wdata;
               `MDT_OFS_SWV: begin
                  // Vector is kept while a software activation is queued, unless the write sets GO again
                  if (!swv_ff[`MDT_SWV_GO] || reg_wdata[`MDT_SWV_GO])
                     swv_ff <= reg_wdata;
                  if (reg_wdata[`MDT_SWV_GO])
                     sw_done_ff <= 1'b0;
               end
               default: ;
            endcase
         end

         if (reg_rd) begin
            case (reg_addr)
               `MDT_OFS_EN_A: reg_rdata <= en_ff[31:24];
               `MDT_OFS_EN_B: reg_rdata <= en_ff[23:16];
               `MDT_OFS_EN_C: reg_rdata <= en_ff[15:8];
               `MDT_OFS_EN_D: reg_rdata <= en_ff[7:0];
               `MDT_OFS_SWV: reg_rdata <= swv_ff;
               `MDT_OFS_STAT: reg_rdata <= {sw_done_ff, act_sw_ff, state_ff != S_IDLE, act_src_ff};
               default: reg_rdata <= 8'h00;
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule

/* File: mdt_engine_chk.sv */
// Port checker for the transfer engine.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "mdt_regs.vh"
module mdt_engine_chk (
   input wire clk,
   input wire rst_b,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [23:0] src_req,
   input wire [23:0] cpu_irq,
   input wire cpu_bus_req,
   input wire cpu_bus_gnt,
   input wire mem_req,
   input wire [23:0] mem_addr,
   input wire mem_we,
   input wire [1:0] mem_size,
   input wire mem_ack
);
   // ----
   // Properties
   // ----
   default clocking dc @(posedge clk); endclocking
   property p_route; disable iff (!rst_b) (cpu_irq & ~src_req) == 24'h000000; endproperty
   a_route: assert property (p_route) else $error("irq without request");
   property p_excl; disable iff (!rst_b) !(mem_req && cpu_bus_gnt); endproperty
   a_excl: assert property (p_excl) else $error("two bus masters");
   property p_rel; disable iff (!rst_b) cpu_bus_gnt && !cpu_bus_req |=> !cpu_bus_gnt; endproperty
   a_rel: assert property (p_rel) else $error("cpu grant kept");
   property p_hold;
      disable iff (!rst_b) mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_size);
   endproperty
   a_hold: assert property (p_hold) else $error("access changed before ack");
   property p_rd; disable iff (!rst_b) !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rd: assert property (p_rd) else $error("read data without read");
   property p_vec;
      disable iff (!rst_b) $rose(mem_req) |-> !mem_we && mem_size == `MDT_SIZE_WORD && mem_addr[23:8] == 16'h0004;
   endproperty
   a_vec: assert property (p_vec) else $error("first access not vector read");
   property p_desc; disable iff (!rst_b) mem_req && mem_size == `MDT_SIZE_LONG |-> mem_addr[23:16] == `MDT_RAM_PAGE;
   endproperty
   a_desc: assert property (p_desc) else $error("descriptor outside ram page");
   property p_wb; disable iff (!rst_b) $rose(mem_req) |-> ##[1:1000] mem_ack && mem_we && mem_size == `MDT_SIZE_LONG;
   endproperty
   a_wb: assert property (p_wb) else $error("no descriptor write back");
   property p_rst; !rst_b |=> !mem_req && !cpu_bus_gnt && reg_rdata == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("outputs active in reset");
   c_act: cover property ($rose(mem_req));
   c_cpu: cover property (cpu_bus_gnt);
   c_irq: cover property (cpu_irq != 24'h000000);
endmodule
bind mdt_engine mdt_engine_chk i_mdt_engine_chk (.clk(clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .src_req(src_req), .cpu_irq(cpu_irq), .cpu_bus_req(cpu_bus_req), .cpu_bus_gnt(cpu_bus_gnt), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_we(mem_we), .mem_size(mem_size), .mem_ack(mem_ack));

/* File: mdt_engine_test.sv */
// Self-checking bench for the transfer engine with a reference model.
// Assumes the memory model answers every engine access.
`timescale 1ns/1ps
`include "mdt_regs.vh"
module mdt_engine_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cpu_bus_req = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [23:0] src_req = 24'h000000;
   wire [7:0] reg_rdata;
   wire [23:0] cpu_irq;
   wire [23:0] mem_addr;
   wire [31:0] mem_wdata;
   wire [31:0] mem_rdata;
   wire [1:0] mem_size;
   wire cpu_bus_gnt;
   wire mem_req;
   wire mem_we;
   wire mem_ack;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h0000A784;
   byte unsigned rm[int];
   logic [7:0] tma[7] = '{8'hA0, 8'hC1, 8'hA4, 8'hBB, 8'h28, 8'hA0, 8'hF0};
   logic [15:0] tca[7] = '{16'h0005, 16'h0001, 16'h0301, 16'h0404, 16'h0303, 16'h0002, 16'h0000};
   logic [15:0] tcb[7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0001, 16'h0000, 16'h0000};
   mdt_engine i_mdt_engine (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .cpu_irq(cpu_irq), .cpu_bus_req(cpu_bus_req),
      .cpu_bus_gnt(cpu_bus_gnt), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we), .mem_size(mem_size),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   mdt_mem_model i_mdt_mem_model (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   always #20 clk = ~clk;
   // CPU asks for the bus in bursts so arbitration is exercised throughout
   always @(posedge clk) begin
      cyc <= cyc + 1;
      cpu_bus_req <= (cyc % 13) < 3;
   end
   // ----
   // Helpers and reference model
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic int gl(int a, int n);
      int v = 0;
      for (int i = 0; i < n; i++) v = (v << 8) | rm[a + i];
      return v;
   endfunction
   function automatic void pl(int a, int n, int v);
      for (int i = 0; i < n; i++) rm[a + i] = 8'(v >> (8 * (n - 1 - i)));
   endfunction
   task automatic put(input int a, input int n, input int v);
      pl(a, n, v);
      for (int i = 0; i < n; i++) i_mdt_mem_model.m[a + i] = rm[a + i];
   endtask
   function automatic void run(int d);
      int ma, mb, s, t, ca, cb, st, ds, dt, n, rl;
      do begin
         ma = rm[d];
         s = gl(d + 1, 3);
         mb = rm[d + 4];
         t = gl(d + 5, 3);
         ca = gl(d + 8, 2);
         cb = gl(d + 10, 2);
         st = ma[0] ? 2 : 1;
         ds = ma[7:6] == 2 ? st : ma[7:6] == 3 ? -st : 0;
         dt = ma[5:4] == 2 ? st : ma[5:4] == 3 ? -st : 0;
         n = ma[3:2] == 2 ? (ca[7:0] == 0 ? 256 : ca[7:0]) : 1;
         rl = ma[3:2] == 2 ? n : (ca[15:8] == 0 ? 256 : ca[15:8]);
         for (int i = 0; i < n; i++) begin
            for (int b = 0; b < st; b++) rm[t + b] = rm[s + b];
            s = (s + ds) & 24'hFFFFFF;
            t = (t + dt) & 24'hFFFFFF;
         end
         if (ma[3:2] == 0) ca = (ca - 1) & 16'hFFFF;
         else if (ma[3:2] == 1) ca[7:0] = ca[7:0] - 1;
         if (ma[3:2] == 2 || (ma[3:2] == 1 && ca[7:0] == 0)) begin
            if (ma[1]) s = (s - rl * ds) & 24'hFFFFFF;
            else t = (t - rl * dt) & 24'hFFFFFF;
            ca[7:0] = ca[15:8];
            if (ma[3:2] == 2) cb = (cb - 1) & 16'hFFFF;
         end
         pl(d + 1, 3, s);
         pl(d + 5, 3, t);
         pl(d + 8, 2, ca);
         pl(d + 10, 2, cb);
         d += 12;
      end while (mb[7]);
   endfunction
   // Descriptors stay in the on-chip RAM page; data sources at even 100000-3FFFFE, destinations at even 800000-BFFFFE
   task automatic mk(input int v, input int d, input int ma, input int mb, input int ca, input int cb);
      int s;
      int t;
      s = 24'h100000 | (rnd() & 24'h3FFFFE);
      t = 24'h800000 | (rnd() & 24'h3FFFFE);
      put(24'h000400 + v * 2, 2, d & 24'h00FFFF);
      put(d, 1, ma);
      put(d + 1, 3, s);
      put(d + 4, 1, mb);
      put(d + 5, 3, t);
      put(d + 8, 2, ca);
      put(d + 10, 2, cb);
      for (int i = -24; i < 24; i++) put(s + i, 1, rnd() & 32'h000000FF);
   endtask
   task automatic cmp_mem();
      check(i_mdt_mem_model.m.num(), rm.num());
      foreach (rm[a]) check(i_mdt_mem_model.m[a], rm[a]);
   endtask
   task automatic act(input logic [23:0] mask);
      int k;
      k = 0;
      @(posedge clk);
      src_req <= mask;
      @(posedge clk);
      #1;
      check(cpu_irq & mask, 24'h000000);
      while ((cpu_irq & mask) !== mask && k < 3000) begin
         @(posedge clk);
         #1;
         k++;
      end
      check(cpu_irq & mask, mask);
      @(posedge clk);
      src_req <= 24'h000000;
   endtask
   // ----
   // Scenarios
   // ----
   initial begin
      logic [7:0] r;
      int d;
      int k;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], r);
         check(r, 8'h00);
      end
      for (int a = 0; a < 4; a++) begin
         wr(a[2:0], 8'hA5 ^ a[7:0]);
         rd(a[2:0], r);
         check(r, 8'hA5 ^ a[7:0]);
         wr(a[2:0], 8'h00);
      end
      wr(3'h6, 8'hFF);
      rd(3'h6, r);
      check(r, 8'h00);
      for (int c = 0; c < 7; c++) begin
         d = 24'hFFEC00 + c * 32;
         mk(c + 1, d, tma[c], c == 5 ? 8'h80 : 8'h00, tca[c], tcb[c]);
         if (c == 5) mk(c + 65, d + 12, 8'hA0, 8'h00, 16'h0002, 16'h0000);
         wr(`MDT_OFS_SWV, 8'h80 | c[7:0] + 8'h01);
         k = 0;
         do begin
            rd(`MDT_OFS_SWV, r);
            k++;
         end while (r[7] && k < 500);
         check(r[7], 1'b0);
         run(d);
         cmp_mem();
         rd(`MDT_OFS_STAT, r);
         check({r[7], r[5]}, 2'b10);
      end
      mk(16, 24'hFFED00, 8'hA0, 8'h00, 16'h0002, 16'h0000);
      wr(`MDT_OFS_EN_A, 8'h80);
      act(24'h000001);
      run(24'hFFED00);
      run(24'hFFED00);
      cmp_mem();
      mk(49, 24'hFFED40, 8'hA0, 8'h40, 16'h0005, 16'h0000);
      wr(`MDT_OFS_EN_A, 8'h02);
      act(24'h000020);
      run(24'hFFED40);
      cmp_mem();
      mk(49, 24'hFFED80, 8'hA0, 8'h00, 16'h0001, 16'h0000);
      mk(94, 24'hFFEDC0, 8'hA0, 8'h00, 16'h0001, 16'h0000);
      put(24'hFFEDC5, 3, gl(24'hFFED85, 3));
      wr(`MDT_OFS_EN_A, 8'h02);
      wr(`MDT_OFS_EN_D, 8'h08);
      act(24'h800020);
      run(24'hFFED80);
      run(24'hFFEDC0);
      cmp_mem();
      rd(`MDT_OFS_EN_A, r);
      check(r, 8'h00);
      rd(`MDT_OFS_EN_D, r);
      check(r, 8'h00);
      test_done();
   end
   initial begin
      #(40 * 90000);
      errors++;
      test_done();
   end
endmodule

/* File: mdt_mem_model.sv */
// Byte-addressed big-endian memory on the engine bus.
// Assumes the request holds steady until acknowledged.
`timescale 1ns/1ps
module mdt_mem_model (
   input wire clk,
   input wire rst_b,
   input wire mem_req,
   input wire [23:0] mem_addr,
   input wire mem_we,
   input wire [1:0] mem_size,
   input wire [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] m[int];
   int acc = 0;
   int dly = 0;
   int nb;
   logic [31:0] v;
   initial mem_rdata = 32'h00000000;
   initial mem_ack = 1'b0;
   // Latency cycles 1..3 so prompt and slow answers both occur
   always @(posedge clk) begin
      nb = 1 << mem_size;
      v = ~mem_rdata;
      if (!rst_b || mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= v;
      end else if (mem_req && dly < acc % 3) begin
         dly <= dly + 1;
      end else if (mem_req) begin
         for (int i = 0; i < nb; i++) begin
            if (mem_we) m[mem_addr + i] = mem_wdata[8 * (nb - 1 - i) +: 8];
            else v[8 * (nb - 1 - i) +: 8] = m[mem_addr + i];
         end
         mem_rdata <= v;
         mem_ack <= 1'b1;
         dly <= 0;
         acc <= acc + 1;
      end
   end
endmodule

/* File: mdt_regs.vh */
// Constants for the descriptor transfer engine: register offsets, field
// positions, reset values and descriptor memory layout.
// Assumes a byte-wide register port and a 24-bit internal address space.
`ifndef MDT_REGS_VH
`define MDT_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MDT_OFS_EN_A 3'h0
`define MDT_OFS_EN_B 3'h1
`define MDT_OFS_EN_C 3'h2
`define MDT_OFS_EN_D 3'h3
`define MDT_OFS_SWV 3'h4
`define MDT_OFS_STAT 3'h5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MDT_RST_EN 32'h00000000
`define MDT_RST_SWV 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MDT_SWV_GO 7
`define MDT_MRA_SM 7:6
`define MDT_MRA_DM 5:4
`define MDT_MRA_MD 3:2
`define MDT_MRA_DTS 1
`define MDT_MRA_SZ 0
`define MDT_MRB_CHAIN 7
`define MDT_MRB_DISEL 6

// ----------------------------------------
// Modes and address steps
// ----------------------------------------
`define MDT_MD_NORMAL 2'h0
`define MDT_MD_REPEAT 2'h1
`define MDT_MD_BLOCK 2'h2
`define MDT_AM_INC 2'h2
`define MDT_AM_DEC 2'h3

// ----------------------------------------
// Memory layout and bus sizes
// ----------------------------------------
`define MDT_VEC_BASE 24'h000400
`define MDT_RAM_PAGE 8'hFF
`define MDT_DESC_STRIDE 24'h00000C
`define MDT_SIZE_BYTE 2'h0
`define MDT_SIZE_WORD 2'h1
`define MDT_SIZE_LONG 2'h2
`define MDT_NSRC 24

`endif
